// File: dsca_checker.sv
// Port assertions for the strobe capture block
`timescale 1ns/1ns
module dsca_checker (
  input wire mclk, // Clock
  input wire rst_b, // Reset, active low
  input wire strobe_oe_mem, // Strobe driven
  input wire group_b_wide, // Wide group
  input wire write_active, // Write burst
  input wire read_strobe_shifted, // Read strobe
  input wire write_strobe_shifted, // Write strobe
  input wire capture_edge_select, // Polarity
  input wire capture_valid, // Word pulse
  input wire [15:0] rd_data, // Head word
  input wire rd_valid, // Head valid
  input wire rd_ready, // Consumer ready
  input wire [4:0] group_cells // Group size
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Head stalled, head taken
  sequence s_wait; rd_valid && !rd_ready; endsequence
  sequence s_pop; rd_valid && rd_ready; endsequence
  AST_CELLS: assert property ($stable(group_b_wide)[*3] |-> group_cells == (group_b_wide ? 5'h0e : 5'h0c))
    else $error("group size");
  AST_WR_GATE: assert property (!write_active[*3] |-> !write_strobe_shifted)
    else $error("write strobe");
  AST_RD_GATE: assert property (!strobe_oe_mem[*8] |-> !read_strobe_shifted)
    else $error("read strobe");
  // Select moves two edges after the rise; the drive flag behind it was sampled four edges back
  AST_SEL: assert property ($changed(capture_edge_select) |-> $past(strobe_oe_mem, 4))
    else $error("select moved");
  AST_PULSE: assert property (capture_valid |=> !capture_valid)
    else $error("valid pulse");
  AST_OUT: assert property (capture_valid |-> ##[0:3] rd_valid)
    else $error("word lost");
  AST_HOLD: assert property (s_wait |=> rd_valid && $stable(rd_data))
    else $error("head moved");
  AST_POP: assert property (s_pop |=> !rd_valid)
    else $error("no gap");
endmodule
bind dsca_top dsca_checker dsca_checker_inst (.mclk(mclk), .rst_b(rst_b), .strobe_oe_mem(strobe_oe_mem),
  .group_b_wide(group_b_wide), .write_active(write_active), .read_strobe_shifted(read_strobe_shifted),
  .write_strobe_shifted(write_strobe_shifted), .capture_edge_select(capture_edge_select),
  .capture_valid(capture_valid), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
  .group_cells(group_cells));

// File: dsca_defines.vh
// Constants for the strobe capture and alignment block
`ifndef DSCA_DEFINES_VH
`define DSCA_DEFINES_VH
`define DSCA_CELLS_MAX 5'h0e
`define DSCA_CELLS_MIN 5'h0c
`define DSCA_DATA_W 16
`define DSCA_HALF_W 8
`define DSCA_CAL_W 6
`define DSCA_FIFO_W 16
`define DSCA_FIFO_D 16
`define DSCA_FIFO_AW 4
`define DSCA_PRE_IDLE 2'h0
`define DSCA_PRE_LOW 2'h1
`define DSCA_PRE_BURST 2'h2
`define DSCA_DLY_W 7
`endif

// File: dsca_fifo.v
// Parameterised valid/ready FIFO for captured read words
`timescale 1ns/1ns
module dsca_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire mclk, // System clock
  input wire rst_b, // Asynchronous reset, active low
  input wire [WIDTH-1:0] in_data, // Write data
  input wire in_valid, // Write request
  output wire in_ready, // Space available
  output wire [WIDTH-1:0] out_data, // Head word
  output wire out_valid, // Head word present
  input wire out_ready // Consumer accepts head
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire push;
  wire pop;
  // Extra pointer bit separates full from empty: full when only that bit differs
  assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Storage has no reset to keep it RAM-friendly
  always @(posedge mclk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  // Pointers
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// File: dsca_mem.sv
// Memory model driving the strobe and data pins on reads
`timescale 1ns/1ns
module dsca_mem (
  output logic strobe_in, // Strobe wire
  output logic strobe_oe_mem, // High while driving
  output logic [7:0] dq_in // Data wire
);
  // Parked strobe rests at termination
  initial begin
    strobe_in = 1'b1;
    strobe_oe_mem = 1'b0;
    dq_in = 8'h00;
  end
  // Low preamble, then the opening rise
  task open_burst;
    begin
      strobe_oe_mem = 1'b1;
      strobe_in = 1'b0;
      #32 strobe_in = 1'b1;
      #16;
    end
  endtask
  // Data set up 4 ns before each edge
  task beat(input [7:0] b);
    begin
      dq_in = b;
      #4 strobe_in = ~strobe_in;
      #12;
    end
  endtask
  // Data inverted on release so no stale byte lingers
  task close_burst;
    begin
      #16 strobe_oe_mem = 1'b0;
      strobe_in = 1'b1;
      dq_in = ~dq_in;
    end
  endtask
endmodule

// File: dsca_top.v
// Strobe control element: strobe shifting, capture polarity, DDR capture
`timescale 1ns/1ns
`include "dsca_defines.vh"
module dsca_top (
  input wire mclk, // System clock, 250 MHz
  input wire rst_b, // Asynchronous reset, active low
  input wire strobe_in, // Incoming data strobe pin
  input wire strobe_oe_mem, // High while memory drives strobe
  input wire [`DSCA_HALF_W-1:0] dq_in, // Data pins, eight per group
  input wire group_b_wide, // High: second group holds 14 cells
  input wire [`DSCA_CAL_W-1:0] dll_code, // Delay calibration code
  input wire write_active, // Write burst in progress
  output reg read_strobe_shifted, // Shifted read strobe
  output reg write_strobe_shifted, // Shifted write strobe
  output reg capture_edge_select, // Capture polarity
  output reg capture_valid, // Captured word valid pulse
  output reg [`DSCA_DATA_W-1:0] rd_data, // Head of read FIFO
  output reg rd_valid, // Read data present
  input wire rd_ready, // Consumer accepts read data
  output reg fifo_full, // FIFO cannot take a word
  output reg [4:0] group_cells // Cells in the wide group
);
  // Two-flop synchronisers; first stage read only by the second
  reg [1:0] sync1_q;
  reg [1:0] sync2_q;
  reg strobe_d1_q;
  wire [`DSCA_HALF_W-1:0] dq_sync;
  reg [`DSCA_DLY_W-1:0] dly_q;
  reg [`DSCA_DLY_W-1:0] tap_q;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [`DSCA_CAL_W-1:0] code_q;
  reg [`DSCA_HALF_W-1:0] lo_q;
  reg have_lo_q;
  reg word_v_q;
  reg [`DSCA_DATA_W-1:0] word_q;
  reg sel_q;
  wire s_strobe = sync2_q[0];
  wire s_oe = sync2_q[1];
  wire rise = s_strobe && !strobe_d1_q;
  wire fall = !s_strobe && strobe_d1_q;
  wire f_ready;
  wire [`DSCA_DATA_W-1:0] f_data;
  wire f_valid;
  // Edge select of the synchronised strobe: fall when pol is set, rise otherwise
  function edge_sel;
    input pol;
    input r;
    input f;
    begin
      edge_sel = pol ? f : r;
    end
  endfunction
  // Strobe and drive flag; reset to the parked level so no false rise follows reset
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 2'h1;
      sync2_q <= 2'h1;
      strobe_d1_q <= 1'b1;
    end else begin
      sync1_q <= {strobe_oe_mem, strobe_in};
      sync2_q <= sync1_q;
      strobe_d1_q <= s_strobe;
    end
  end
  // Data pins: one two-flop synchroniser per cell, same latency as the strobe path
  // Equal latency keeps each byte aligned with the edge that qualifies it
  genvar gi;
  generate
    for (gi = 0; gi < `DSCA_HALF_W; gi = gi + 1) begin : g_dq_sync
      reg meta_q;
      reg stable_q;
      always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q <= dq_in[gi];
          stable_q <= meta_q;
        end
      end
      assign dq_sync[gi] = stable_q;
    end
  endgenerate
  // Calibration code moves slowly; a single stage is enough on the same clock
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      code_q <= 6'h00;
    end else begin
      code_q <= dll_code;
    end
  end
  // Delay line of strobe samples; calibration code picks the tap
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dly_q <= 7'h00;
      tap_q <= 7'h00;
    end else begin
      dly_q <= {dly_q[`DSCA_DLY_W-2:0], s_strobe};
      tap_q <= {dly_q[`DSCA_DLY_W-2:0], s_strobe} >> code_q[2:0];
    end
  end
  // Preamble tracker: parked, driven low, then bursting
  always @* begin
    st_d = st_q;
    case (st_q)
      `DSCA_PRE_IDLE: begin
        if (s_oe && !s_strobe) begin
          st_d = `DSCA_PRE_LOW;
        end
      end
      `DSCA_PRE_LOW: begin
        if (!s_oe) begin
          st_d = `DSCA_PRE_IDLE;
        end else if (rise) begin
          st_d = `DSCA_PRE_BURST;
        end
      end
      `DSCA_PRE_BURST: begin
        if (!s_oe) begin
          st_d = `DSCA_PRE_IDLE;
        end
      end
      default: begin
        st_d = `DSCA_PRE_IDLE;
      end
    endcase
  end
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= `DSCA_PRE_IDLE;
      sel_q <= 1'b0;
    end else begin
      st_q <= st_d;
      // Polarity latched at first rise; top calibration code bit decides edge (XOR with prior strobe sample, low at a rise)
      // Same condition as the tracker: a rise seen as the drive drops is no burst start
      if (st_q == `DSCA_PRE_LOW && rise && s_oe) begin
        sel_q <= code_q[`DSCA_CAL_W-1] ^ dly_q[0];
      end
    end
  end
  // Capture: two beats pair into one word, low beat first
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lo_q <= 8'h00;
      have_lo_q <= 1'b0;
      word_v_q <= 1'b0;
      word_q <= 16'h0000;
    end else begin
      word_v_q <= 1'b0;
      if (st_q != `DSCA_PRE_BURST) begin
        have_lo_q <= 1'b0; // Odd beat dropped at burst end
      end else if ((rise || fall) && s_oe) begin
        // The step back to the parked level on release is not a beat
        // Without this gate an odd burst would close with a false word
        if (!have_lo_q) begin
          lo_q <= dq_sync;
          have_lo_q <= 1'b1;
        end else begin
          word_q <= {dq_sync, lo_q};
          word_v_q <= f_ready;
          have_lo_q <= 1'b0;
        end
      end
    end
  end
  dsca_fifo #(
    .WIDTH(`DSCA_FIFO_W),
    .DEPTH(`DSCA_FIFO_D),
    .AW(`DSCA_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_data(word_q),
    .in_valid(word_v_q),
    .in_ready(f_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(rd_ready && rd_valid)
  );
  // Registered outputs; rd_data/rd_valid lag the FIFO head by one cycle
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      read_strobe_shifted <= 1'b0;
      write_strobe_shifted <= 1'b0;
      capture_edge_select <= 1'b0;
      capture_valid <= 1'b0;
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
      fifo_full <= 1'b0;
      group_cells <= 5'h00;
    end else begin
      read_strobe_shifted <= tap_q[0] & s_oe;
      write_strobe_shifted <= tap_q[0] & write_active;
      capture_edge_select <= sel_q;
      capture_valid <= word_v_q && edge_sel(1'b0, 1'b1, 1'b0);
      rd_data <= f_data;
      rd_valid <= f_valid && !(rd_ready && rd_valid);
      fifo_full <= !f_ready;
      group_cells <= group_b_wide ? `DSCA_CELLS_MAX : `DSCA_CELLS_MIN;
    end
  end
endmodule

// File: tb.sv
// Self-checking bench for the strobe capture block
`timescale 1ns/1ns
module tb;
  reg mclk = 1'b0;
  reg rst_b = 1'b0;
  reg wide = 1'b0;
  reg [5:0] code = 6'h00;
  reg wr = 1'b0;
  reg rdy = 1'b0;
  reg rdy_en = 1'b0;
  reg [31:0] seed = 32'h41f8101e;
  reg [31:0] rs = 32'h41f8101e;
  reg [15:0] w;
  reg [15:0] exp_q[$];
  integer error_cnt = 0;
  integer check_count = 0;
  integer acc_cnt = 0;
  integer cv_cnt = 0;
  integer i, k;
  wire so, soe, rss, wss, sel, cv, rv, full;
  wire [7:0] dq;
  wire [15:0] rd;
  wire [4:0] gc;
  dsca_mem dsca_mem_inst (.strobe_in(so), .strobe_oe_mem(soe), .dq_in(dq));
  dsca_top dsca_top_inst (.mclk(mclk), .rst_b(rst_b), .strobe_in(so), .strobe_oe_mem(soe), .dq_in(dq),
    .group_b_wide(wide), .dll_code(code), .write_active(wr), .read_strobe_shifted(rss),
    .write_strobe_shifted(wss), .capture_edge_select(sel), .capture_valid(cv), .rd_data(rd), .rd_valid(rv),
    .rd_ready(rdy), .fifo_full(full), .group_cells(gc));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Cell count of the wide group for a given width choice
  function [15:0] exp_cells(input wd);
    exp_cells = wd ? 16'h000e : 16'h000c;
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      if (error_cnt == 0 && check_count > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  // Words past cap are expected to be refused
  task burst(input integer n, input odd, input integer cap);
    begin
      // Step off the sampling edge so pin changes never race the synchronisers
      #1;
      dsca_mem_inst.open_burst;
      for (i = 0; i < n; i = i + 1) begin
        seed = lfsr(seed);
        w = seed[15:0];
        if (exp_q.size() < cap) begin
          exp_q.push_back(w);
          acc_cnt = acc_cnt + 1;
        end
        dsca_mem_inst.beat(w[7:0]);
        dsca_mem_inst.beat(w[15:8]);
      end
      if (odd) dsca_mem_inst.beat(8'h5a);
      dsca_mem_inst.close_burst;
    end
  endtask
  initial forever #2 mclk = ~mclk;
  // Random stalls make the head wait
  always @(posedge mclk) begin
    rs <= lfsr(rs);
    rdy <= rdy_en & rs[3];
    if (rv && rdy) chk(rd, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
  end
  // Count capture pulses, one per word the FIFO accepted
  always @(posedge mclk) begin
    if (cv) begin
      cv_cnt <= cv_cnt + 1;
    end
  end
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    rdy_en <= 1'b1;
    for (k = 0; k < 4; k = k + 1) begin
      @(posedge mclk);
      seed = lfsr(seed);
      wide <= seed[0];
      // Top code bit alternates 0,1,0,1, so the select has to move on every read after the first
      code <= {k[0], seed[5:1]};
      wr <= seed[7];
      burst(3 + k, k[0], 99);
      repeat (40) @(posedge mclk);
      chk(16'(gc), exp_cells(wide));
      chk(16'(exp_q.size()), 16'h0000);
      chk(16'(sel), 16'(code[5]));
    end
    // Stalled consumer: the FIFO fills and two words are dropped
    rdy_en <= 1'b0;
    burst(18, 1'b0, 16);
    repeat (10) @(posedge mclk);
    chk(16'(full), 16'h0001);
    rdy_en <= 1'b1;
    repeat (200) @(posedge mclk);
    chk(16'(exp_q.size()), 16'h0000);
    chk(16'(full), 16'h0000);
    chk(16'(cv_cnt), 16'(acc_cnt));
    give_verdict;
  end
endmodule
